// ===== rtl/backup_domain_pkg.sv
// Operation
// R01: The block holds sixteen 16-bit user data registers, 32 bytes in all, in the backup domain.
// R02: User data survives system reset, power reset and standby wake-up and clears only on backup reset.
// R03: After reset, bus writes to the backup registers are blocked until access is granted.
// R04: Software first enables the power and backup interface clocks, then sets write permission.
// R05: Each user data register is a read-write 16-bit field that is zero after a backup reset.
// R06: With the pulse output enabled, bit 9 routes the alarm pulse when 0, the second pulse when 1.
// R07: Bit 8 drives the selected pulse, one RTC clock period long, onto the pin; clearing it stops it.
// R08: The select and pulse enable bits clear only on a backup reset, not on system or power resets.
// R09: Software keeps the pin's general-purpose function off while the pulse output is enabled.
// R10: Bit 7 puts the RTC clock divided by 64 on the shared pin; writing zero to it has no effect.
// R11: The calibration clock output bit clears whenever the main supply is powered off.
// R12: The 7-bit calibration value counts RTC pulses suppressed in every window of 2^20 pulses.
// R13: Calibration register bits 15 to 10 read zero and ignore writes; it resets to zero.
package backup_domain_pkg;
	localparam int DATA_COUNT = 16;
	localparam int DATA_WIDTH = 16;
	localparam int CAL_WIDTH = 7;
	localparam int WINDOW_BITS = 20;
	localparam int DIVIDER = 64;
	localparam int DIV_BITS = $clog2(DIVIDER);
	localparam logic [7:0] DATA_BASE_OFFSET = 8'h00;
	localparam logic [7:0] CAL_OFFSET = 8'h40;
	localparam logic [7:0] STATUS_OFFSET = 8'h44;
	localparam int SELECT_BIT = 9;
	localparam int ENABLE_BIT = 8;
	localparam int CCO_BIT = 7;
	localparam int STATUS_GRANTED_BIT = 0;
	localparam int STATUS_PIN_BIT = 1;
	localparam logic [DATA_WIDTH-1:0] DATA_RESET = 16'h0000;
	localparam logic [CAL_WIDTH-1:0] CAL_RESET = 7'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// ===== rtl/backup_domain_registers.sv
`timescale 1ns/1ns
module backup_domain_registers
	import backup_domain_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic backup_resetn,
	input wire logic main_supply_off,
	input wire logic power_interface_clock_enable,
	input wire logic backup_interface_clock_enable,
	input wire logic backup_write_permission,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rtc_tick,
	input wire logic alarm_pulse,
	input wire logic second_pulse,
	output logic calibrated_rtc_tick,
	output logic shared_rtc_output_pin,
	output logic shared_rtc_output_enable
);
	logic [DATA_WIDTH-1:0] data [DATA_COUNT];
	logic [DATA_WIDTH-1:0] next_data [DATA_COUNT];
	logic pulse_output_select;
	logic pulse_output_enable;
	logic calibration_clock_output;
	logic [CAL_WIDTH-1:0] cal_value;
	logic next_pulse_output_select;
	logic next_pulse_output_enable;
	logic next_calibration_clock_output;
	logic [CAL_WIDTH-1:0] next_cal_value;
	logic [WINDOW_BITS-1:0] window_count;
	logic [WINDOW_BITS-1:0] next_window_count;
	logic [DIV_BITS-1:0] div_count;
	logic [DIV_BITS-1:0] next_div_count;
	logic pulse_hold;
	logic next_pulse_hold;
	logic next_calibrated_rtc_tick;
	logic next_pin;
	logic next_pin_enable;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic granted;
	logic access;
	logic setup;

	// Data registers sit on word boundaries from the base offset upward.
	function automatic logic is_data_addr(input logic [7:0] addr);
		return (addr >= DATA_BASE_OFFSET) && (addr < CAL_OFFSET) && (addr[1:0] == 2'b00);
	endfunction

	function automatic logic is_mapped(input logic [7:0] addr);
		return is_data_addr(addr) || (addr == CAL_OFFSET) || (addr == STATUS_OFFSET);
	endfunction

	// Both interface clocks and the permission bit must be on before writes land.
	assign granted = power_interface_clock_enable && backup_interface_clock_enable &&
		backup_write_permission; // R03 R04
	assign setup = psel && !penable;
	assign access = psel && penable && pready;

	// Read data and the answer are prepared in the setup cycle so every bus output is a flop.
	always_comb begin
		next_pready = setup;
		next_pslverr = 1'b0;
		next_prdata = READ_ZERO;
		if (setup) begin
			if (!is_mapped(paddr)) begin
				next_pslverr = 1'b1;
			end else if (pwrite && !granted && paddr != STATUS_OFFSET) begin
				next_pslverr = 1'b1; // R03
			end else if (!pwrite) begin
				if (is_data_addr(paddr)) begin
					next_prdata[DATA_WIDTH-1:0] = data[paddr[5:2]];
				end else if (paddr == CAL_OFFSET) begin
					next_prdata[SELECT_BIT] = pulse_output_select; // R13
					next_prdata[ENABLE_BIT] = pulse_output_enable;
					next_prdata[CCO_BIT] = calibration_clock_output;
					next_prdata[CAL_WIDTH-1:0] = cal_value;
				end else begin
					next_prdata[STATUS_GRANTED_BIT] = granted;
					next_prdata[STATUS_PIN_BIT] = shared_rtc_output_pin;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= READ_ZERO;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// Register writes; the supply-off clear is applied last so it always wins.
	always_comb begin
		for (int i = 0; i < DATA_COUNT; i++) begin
			next_data[i] = data[i];
		end
		next_pulse_output_select = pulse_output_select;
		next_pulse_output_enable = pulse_output_enable;
		next_calibration_clock_output = calibration_clock_output;
		next_cal_value = cal_value;
		if (access && pwrite && granted) begin // R03
			if (is_data_addr(paddr)) begin
				next_data[paddr[5:2]] = pwdata[DATA_WIDTH-1:0]; // R01 R05
			end else if (paddr == CAL_OFFSET) begin
				next_pulse_output_select = pwdata[SELECT_BIT]; // R06
				next_pulse_output_enable = pwdata[ENABLE_BIT]; // R07
				if (pwdata[CCO_BIT]) begin
					next_calibration_clock_output = 1'b1; // R10
				end
				next_cal_value = pwdata[CAL_WIDTH-1:0]; // R12 R13
			end
		end
		if (main_supply_off) begin
			next_calibration_clock_output = 1'b0; // R11
		end
	end

	// The first cal_value ticks of each window are swallowed, slowing the RTC.
	always_comb begin
		next_window_count = window_count;
		next_div_count = div_count;
		next_pulse_hold = pulse_hold;
		next_calibrated_rtc_tick = 1'b0;
		if (rtc_tick) begin
			next_window_count = window_count + WINDOW_BITS'(1);
			next_div_count = div_count + DIV_BITS'(1);
			next_pulse_hold = pulse_output_select ? second_pulse : alarm_pulse; // R06 R07
			next_calibrated_rtc_tick = (window_count >= WINDOW_BITS'(cal_value)); // R12
		end
		next_pin_enable = calibration_clock_output || pulse_output_enable;
		if (calibration_clock_output) begin
			next_pin = div_count[DIV_BITS-1]; // R10
		end else if (pulse_output_enable) begin
			next_pin = pulse_hold; // R07
		end else begin
			next_pin = 1'b0;
		end
	end

	// Only the backup reset reaches this state; system and power resets leave it alone.
	always_ff @(posedge pclk or negedge backup_resetn) begin
		if (!backup_resetn) begin
			for (int i = 0; i < DATA_COUNT; i++) begin
				data[i] <= DATA_RESET; // R02 R05
			end
			pulse_output_select <= 1'b0; // R08
			pulse_output_enable <= 1'b0; // R08
			calibration_clock_output <= 1'b0;
			cal_value <= CAL_RESET; // R13
			window_count <= '0;
			div_count <= '0;
			pulse_hold <= 1'b0;
			calibrated_rtc_tick <= 1'b0;
			shared_rtc_output_pin <= 1'b0;
			shared_rtc_output_enable <= 1'b0;
		end else begin
			data <= next_data;
			pulse_output_select <= next_pulse_output_select;
			pulse_output_enable <= next_pulse_output_enable;
			calibration_clock_output <= next_calibration_clock_output;
			cal_value <= next_cal_value;
			window_count <= next_window_count;
			div_count <= next_div_count;
			pulse_hold <= next_pulse_hold;
			calibrated_rtc_tick <= next_calibrated_rtc_tick;
			shared_rtc_output_pin <= next_pin;
			shared_rtc_output_enable <= next_pin_enable;
		end
	end

	sequence blocked_write_s(logic [7:0] addr);
		psel && penable && pready && pwrite && !granted && paddr == addr;
	endsequence

	sequence granted_write_s(logic [7:0] addr);
		psel && penable && pready && pwrite && granted && paddr == addr;
	endsequence

	// Reads are checked against the state one cycle back, since the answer is built in setup.
	sequence read_setup_s(logic [7:0] addr);
		setup && !pwrite && paddr == addr;
	endsequence

	AST_BLOCKED_DATA: assert property (@(posedge pclk) // R03
		disable iff (!backup_resetn || !presetn)
		blocked_write_s(DATA_BASE_OFFSET) |=> $stable(data[0]))
		else $error("Data register changed without write access.");

	AST_BLOCKED_CAL: assert property (@(posedge pclk) // R03
		disable iff (!backup_resetn || !presetn)
		blocked_write_s(CAL_OFFSET) |=> $stable(cal_value) && $stable(pulse_output_enable))
		else $error("Calibration register changed without write access.");

	AST_DATA_WRITE: assert property (@(posedge pclk) // R05
		disable iff (!backup_resetn || !presetn)
		granted_write_s(DATA_BASE_OFFSET) |=> data[0] == $past(pwdata[15:0]))
		else $error("Granted data write did not store the value.");

	AST_RESERVED_ZERO: assert property (@(posedge pclk) // R13
		disable iff (!backup_resetn || !presetn)
		setup && !pwrite && paddr == CAL_OFFSET |=> pready && prdata[31:10] == 22'h0)
		else $error("Reserved calibration bits read nonzero.");

	AST_CCO_SUPPLY_OFF: assert property (@(posedge pclk) // R11
		disable iff (!backup_resetn)
		main_supply_off |=> !calibration_clock_output)
		else $error("Calibration clock output survived supply off.");

	AST_CCO_ZERO_NO_EFFECT: assert property (@(posedge pclk) // R10
		disable iff (!backup_resetn || !presetn)
		granted_write_s(CAL_OFFSET) ##0 (!pwdata[CCO_BIT] && calibration_clock_output &&
		!main_supply_off) |=> calibration_clock_output)
		else $error("Writing zero cleared the calibration clock output.");

	AST_PIN_DIVIDED: assert property (@(posedge pclk) // R10
		disable iff (!backup_resetn)
		calibration_clock_output |=> shared_rtc_output_pin == $past(div_count[DIV_BITS-1]))
		else $error("Pin does not follow the divided RTC clock.");

	AST_PULSE_SELECT: assert property (@(posedge pclk) // R06
		disable iff (!backup_resetn)
		rtc_tick |=> pulse_hold == ($past(pulse_output_select) ? $past(second_pulse) :
		$past(alarm_pulse)))
		else $error("Wrong pulse source captured.");

	AST_PULSE_PIN: assert property (@(posedge pclk) // R07
		disable iff (!backup_resetn)
		!calibration_clock_output && pulse_output_enable |=>
		shared_rtc_output_pin == $past(pulse_hold) && shared_rtc_output_enable)
		else $error("Pulse output not driven onto the pin.");

	AST_PIN_OFF: assert property (@(posedge pclk) // R07
		disable iff (!backup_resetn)
		!calibration_clock_output && !pulse_output_enable |=>
		!shared_rtc_output_pin && !shared_rtc_output_enable)
		else $error("Pin driven while both outputs are off.");

	AST_CAL_SKIP: assert property (@(posedge pclk) // R12
		disable iff (!backup_resetn)
		rtc_tick && window_count < WINDOW_BITS'(cal_value) |=> !calibrated_rtc_tick)
		else $error("Calibration did not suppress a tick.");

	AST_READY_ONE_CYCLE: assert property (@(posedge pclk) // R01
		disable iff (!presetn)
		setup |=> pready ##1 !pready)
		else $error("Ready did not stand for exactly one cycle.");

	AST_BLOCKED_ERROR: assert property (@(posedge pclk) // R03
		disable iff (!presetn)
		setup && pwrite && !granted && is_data_addr(paddr) |=> pslverr)
		else $error("Blocked data write was not refused.");

	AST_GRANTED_OK: assert property (@(posedge pclk) // R03
		disable iff (!presetn)
		setup && pwrite && granted && is_mapped(paddr) |=> !pslverr)
		else $error("Granted write was refused.");

	AST_DATA_READ: assert property (@(posedge pclk) // R05
		disable iff (!backup_resetn || !presetn)
		setup && !pwrite && is_data_addr(paddr) |=> prdata == {16'h0000, $past(data[paddr[5:2]])})
		else $error("Data read returned the wrong value.");

	AST_CAL_READ: assert property (@(posedge pclk) // R13
		disable iff (!backup_resetn || !presetn)
		read_setup_s(CAL_OFFSET) |=> prdata[9:0] == $past({pulse_output_select,
		pulse_output_enable, calibration_clock_output, cal_value}))
		else $error("Calibration read returned the wrong fields.");

	AST_SELECT_KEPT: assert property (@(posedge pclk) // R08
		disable iff (!backup_resetn)
		!(access && pwrite && granted && paddr == CAL_OFFSET) |=>
		$stable(pulse_output_select) && $stable(pulse_output_enable))
		else $error("Pulse select or enable changed without a write.");

	for (genvar g = 0; g < DATA_COUNT; g++) begin : g_data_kept
		AST_DATA_KEPT: assert property (@(posedge pclk) // R02
			disable iff (!backup_resetn)
			!(access && pwrite && granted && paddr == DATA_BASE_OFFSET + 8'(4 * g)) |=>
			$stable(data[g]))
			else $error("Data register changed without a write.");
	end

	AST_CCO_SET: assert property (@(posedge pclk) // R10
		disable iff (!backup_resetn || !presetn)
		granted_write_s(CAL_OFFSET) ##0 (pwdata[CCO_BIT] && !main_supply_off) |=>
		calibration_clock_output)
		else $error("Writing one did not set the calibration clock output.");

	AST_CAL_STORE: assert property (@(posedge pclk) // R12
		disable iff (!backup_resetn || !presetn)
		granted_write_s(CAL_OFFSET) |=> cal_value == $past(pwdata[CAL_WIDTH-1:0]))
		else $error("Calibration value was not stored.");

	AST_TICK_PASS: assert property (@(posedge pclk) // R12
		disable iff (!backup_resetn)
		rtc_tick && window_count >= WINDOW_BITS'(cal_value) |=> calibrated_rtc_tick)
		else $error("An RTC tick past the suppressed count was lost.");

	AST_TICK_IDLE: assert property (@(posedge pclk) // R12
		disable iff (!backup_resetn)
		!rtc_tick |=> !calibrated_rtc_tick)
		else $error("Calibrated tick without an RTC tick.");

	AST_WINDOW_STEP: assert property (@(posedge pclk) // R12
		disable iff (!backup_resetn)
		rtc_tick |=> window_count == $past(window_count) + WINDOW_BITS'(1))
		else $error("Window counter did not advance on an RTC tick.");

	AST_PULSE_HOLD: assert property (@(posedge pclk) // R07
		disable iff (!backup_resetn)
		!rtc_tick |=> $stable(pulse_hold))
		else $error("Routed pulse changed between RTC ticks.");

	AST_PIN_ENABLE: assert property (@(posedge pclk) // R10
		disable iff (!backup_resetn)
		calibration_clock_output |=> shared_rtc_output_enable)
		else $error("Pin not driven while the divided clock is routed.");
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
module testbench import backup_domain_pkg::*;;
	logic pclk = 0, presetn = 0, backup_resetn = 0, main_supply_off = 0;
	logic pwr_clk_en = 0, bkp_clk_en = 0, write_perm = 0;
	logic psel = 0, penable = 0, pwrite = 0, rtc_tick = 0, alarm_pulse = 0, second_pulse = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd, d;
	logic err;
	wire [31:0] prdata;
	wire pready, pslverr, cal_tick, pin, pin_en;
	int errors = 0, check_count = 0, seed = 81143, cycles = 0, ticks_out = 0, pin_changes = 0;
	int mem[16];
	backup_domain_registers i_dut (.pclk(pclk), .presetn(presetn), .backup_resetn(backup_resetn),
		.main_supply_off(main_supply_off), .power_interface_clock_enable(pwr_clk_en),
		.backup_interface_clock_enable(bkp_clk_en), .backup_write_permission(write_perm),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rtc_tick(rtc_tick),
		.alarm_pulse(alarm_pulse), .second_pulse(second_pulse), .calibrated_rtc_tick(cal_tick),
		.shared_rtc_output_pin(pin), .shared_rtc_output_enable(pin_en));
	always #50 pclk = ~pclk;
	// The ceiling is about forty times the expected run of roughly 500 cycles, so only a hang reaches it.
	always @(posedge pclk) begin
		cycles++;
		if (cal_tick === 1'b1) ticks_out++;
		if (cycles > 20000) begin
			errors++;
			end_of_test();
		end
	end
	always @(pin) pin_changes++;
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Only the bench timeout may end a wait for ready; the request stands until then.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		chk(name, rd, exp);
	endtask
	// Pulse inputs are inverted outside tick cycles so a design sampling them late is caught.
	task tick(input logic a, input logic s);
		@(posedge pclk);
		rtc_tick <= 1; alarm_pulse <= a; second_pulse <= s;
		@(posedge pclk);
		rtc_tick <= 0; alarm_pulse <= ~a; second_pulse <= ~s;
	endtask
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		backup_resetn <= 1;
		for (int i = 0; i < 16; i++) rdchk("data reset", 8'(4 * i), 32'h0);
		rdchk("cal reset", CAL_OFFSET, 32'h0);
		rdchk("status locked", STATUS_OFFSET, 32'h0);
		$display("test reset values done");
		apb(1, 8'h00, 32'h0000_1234);
		chk("blocked err", {31'h0, err}, 32'h1);
		rdchk("blocked data", 8'h00, 32'h0);
		apb(1, CAL_OFFSET, 32'h0000_0381);
		chk("blocked cal err", {31'h0, err}, 32'h1);
		rdchk("blocked cal", CAL_OFFSET, 32'h0);
		$display("test write block done");
		pwr_clk_en <= 1; bkp_clk_en <= 1;
		@(posedge pclk);
		write_perm <= 1;
		for (int i = 0; i < 16; i++) begin
			d = $random(seed);
			mem[i] = d[15:0];
			apb(1, 8'(4 * i), d);
			chk("write err", {31'h0, err}, 32'h0);
		end
		rdchk("status granted", STATUS_OFFSET, 32'h1);
		apb(1, 8'h48, 32'h0000_5555);
		chk("unmapped err", {31'h0, err}, 32'h1);
		// The bench never drives the shared pin, so its general-purpose function stays off.
		apb(1, CAL_OFFSET, 32'hffff_ff7f);
		rdchk("cal unused", CAL_OFFSET, 32'h0000_037f);
		apb(1, CAL_OFFSET, 32'h0000_0380);
		apb(1, CAL_OFFSET, 32'h0000_0300);
		rdchk("cco zero write", CAL_OFFSET, 32'h0000_0380);
		@(posedge pclk) main_supply_off <= 1;
		@(posedge pclk) main_supply_off <= 0;
		rdchk("cco supply off", CAL_OFFSET, 32'h0000_0300);
		@(posedge pclk) presetn <= 0;
		@(posedge pclk) presetn <= 1;
		for (int i = 0; i < 16; i++) rdchk("data kept", 8'(4 * i), 32'(mem[i]));
		rdchk("cal kept", CAL_OFFSET, 32'h0000_0300);
		$display("test registers done");
		tick(0, 1);
		@(posedge pclk) #1;
		chk("second pin", {30'h0, pin_en, pin}, 32'h3);
		tick(1, 0);
		@(posedge pclk) #1;
		chk("second low", {31'h0, pin}, 32'h0);
		apb(1, CAL_OFFSET, 32'h0000_0100);
		tick(1, 0);
		@(posedge pclk) #1;
		chk("alarm pin", {30'h0, pin_en, pin}, 32'h3);
		rdchk("status pin", STATUS_OFFSET, 32'h3);
		apb(1, CAL_OFFSET, 32'h0000_0000);
		repeat (2) @(posedge pclk) #1;
		chk("pin off", {31'h0, pin_en}, 32'h0);
		apb(1, CAL_OFFSET, 32'h0000_0080);
		repeat (3) @(posedge pclk);
		pin_changes = 0;
		repeat (128) tick(0, 0);
		repeat (3) @(posedge pclk);
		chk("div64 toggles", 32'(pin_changes), 32'd4);
		$display("test pin output done");
		@(posedge pclk) backup_resetn <= 0;
		@(posedge pclk) backup_resetn <= 1;
		rdchk("data cleared", 8'h3c, 32'h0);
		rdchk("cal cleared", CAL_OFFSET, 32'h0);
		apb(1, CAL_OFFSET, 32'h0000_0003);
		ticks_out = 0;
		repeat (10) tick(0, 0);
		repeat (3) @(posedge pclk);
		chk("suppressed", 32'(ticks_out), 32'd7);
		$display("test calibration done");
		end_of_test();
	end
endmodule
